// ===== core/sdcbi_core.sv
// sdcbi_core: slot decode, pio/dma state machine, buffer address counter, strobes.
// assumes bus inputs arrive asynchronously (two-flop sync) and the chip strobes are
// decoded from the next state and then registered; the card is a pure slave.
module sdcbi_core
    import sdcbi_pkg::*;
#(
    parameter int DMA_CYCLE_LEN = 2
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic start_n_in,
    input wire logic [ADDR_W-1:0] ad_n_in,
    input wire logic tm1_n_in,
    input wire logic [3:0] slot_id_n_in,
    input wire logic dma_request_n_in,
    input wire logic fdc_interrupt_in,
    input wire logic disk_in_place_in,
    input wire sdcbi_drive_t drive_in,
    output logic cycle_active_n_out,
    output logic address_load_n_out,
    output logic ack_window_n_out,
    output logic ack_n_out,
    output logic ack_oe_n_out,
    output logic [1:0] tm_n_out,
    output logic tm_oe_n_out,
    output logic dma_grant_n_out,
    output logic counter_decrement_n_out,
    output logic [BUF_AW-1:0] buffer_addr_out,
    output sdcbi_strobes_t strobes_out,
    output logic internal_op_pending_n_out,
    output logic dma_disk_to_buffer_n_out,
    output logic [7:0] status_word_out,
    output logic motor_on_out,
    output logic fdc_reset_out,
    output logic mux_phase_out,
    output sdcbi_drive_t drive_out
);
    // two-flop synchronisers on every bus-side input
    logic [ADDR_W+6:0] sync_a;
    logic [ADDR_W+6:0] sync_b;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_a <= '1;
            sync_b <= '1;
        end else begin
            sync_a <= {start_n_in, tm1_n_in, dma_request_n_in, slot_id_n_in, ad_n_in};
            sync_b <= sync_a;
        end
    end
    logic start_s;
    logic tm1_s;
    logic dma_request_n_s;
    logic [3:0] slot_id_s;
    logic [ADDR_W-1:0] ad_s;
    // bus lines are active low; invert once here like the transceivers do
    assign ad_s = ~sync_b[ADDR_W-1:0];
    assign slot_id_s = ~sync_b[ADDR_W+3:ADDR_W];
    assign dma_request_n_s = ~sync_b[ADDR_W+4];
    assign tm1_s = ~sync_b[ADDR_W+5];
    assign start_s = ~sync_b[ADDR_W+6];

    function automatic logic slot_hit(input logic [ADDR_W-1:0] a, input logic [3:0] id);
        slot_hit = (a[TOP_NIB_HI:TOP_NIB_LO] == SLOT_SPACE_NIBBLE)
            && (a[SLOT_ID_HI:SLOT_ID_LO] == id);
    endfunction

    sdcbi_state_t state;
    sdcbi_state_t next_state;
    logic [2:0] blk;
    logic [2:0] next_blk;
    logic is_read;
    logic next_is_read;
    logic dma_active;
    logic next_dma_active;
    logic dma_reads_disk;
    logic next_dma_reads_disk;
    logic [BUF_AW-1:0] addr;
    logic [BUF_AW-1:0] next_addr;
    logic [$clog2(DMA_CYCLE_LEN+1)-1:0] dcnt;
    logic [$clog2(DMA_CYCLE_LEN+1)-1:0] next_dcnt;
    logic motor;
    logic next_motor;
    logic fdc_rst;
    logic next_fdc_rst;
    logic pend_slot;
    logic next_pend_slot;
    logic mux_ph;
    logic next_mux_ph;
    logic ald;
    logic hit;
    logic ignore;
    logic start_q;
    logic next_start_q;

    // start is held until ack, so only its first synced cycle counts as a hit
    assign hit = start_s && !start_q && slot_hit(ad_s, slot_id_s);

    always_comb begin
        next_state = state;
        next_blk = blk;
        next_is_read = is_read;
        next_dma_active = dma_active;
        next_dma_reads_disk = dma_reads_disk;
        next_addr = addr;
        next_dcnt = dcnt;
        next_motor = motor;
        next_fdc_rst = fdc_rst;
        next_pend_slot = pend_slot || hit;
        next_mux_ph = ~mux_ph;
        next_start_q = start_s;
        ald = 1'b0;
        ignore = dma_active;
        // captured on the hit itself, so a cycle parked behind dma keeps its block
        if (hit) begin
            next_blk = ad_s[BLK_HI:BLK_LO];
            next_is_read = tm1_s;
        end
        case (state)
            SDC_IDLE: begin
                if (dma_active && dma_request_n_s) begin
                    next_state = SDC_DMA;
                    next_dcnt = '0;
                end else if (pend_slot || hit) begin
                    next_pend_slot = 1'b0;
                    next_state = SDC_S1;
                    if (hit) begin
                        ald = 1'b1;
                    end
                end
            end
            SDC_S1: next_state = SDC_S3;
            SDC_S3: next_state = SDC_S2;
            SDC_S2: begin
                next_state = SDC_IDLE;
                if (!ignore) begin
                    case (blk)
                        BLK_DMA_RD, BLK_DMA_WR: begin
                            if (!is_read) begin
                                next_dma_active = 1'b1;
                                next_dma_reads_disk = (blk == BLK_DMA_RD);
                            end
                        end
                        BLK_MOTOR: begin
                            next_motor = !is_read;
                            if (is_read) begin
                                next_fdc_rst = 1'b0;
                            end
                        end
                        BLK_ROM_RST: begin
                            if (!is_read) begin
                                next_fdc_rst = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            SDC_DMA: begin
                next_dcnt = dcnt + 1'b1;
                if (dcnt == ($clog2(DMA_CYCLE_LEN+1))'(DMA_CYCLE_LEN - 1)) begin
                    next_state = SDC_DEND;
                end
            end
            SDC_DEND: begin
                next_state = SDC_IDLE;
                if (addr == '0) begin
                    next_dma_active = 1'b0; // terminates at zero
                end else begin
                    next_addr = addr - 1'b1;
                end
            end
            default: next_state = SDC_IDLE;
        endcase
        if (ald && !dma_active && (ad_s[BLK_HI:BLK_LO] == BLK_BUFFER
                || ad_s[BLK_HI:BLK_LO] == BLK_ROM_RST
                || ad_s[BLK_HI:BLK_LO] == BLK_DMA_RD
                || ad_s[BLK_HI:BLK_LO] == BLK_DMA_WR)) begin
            next_addr = ad_s[BUF_ADDR_HI:BUF_ADDR_LO];
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= SDC_IDLE;
            blk <= BLK_FDC_STATUS;
            is_read <= 1'b0;
            dma_active <= 1'b0;
            dma_reads_disk <= 1'b0;
            addr <= '0;
            dcnt <= '0;
            motor <= 1'b0;
            fdc_rst <= 1'b0;
            pend_slot <= 1'b0;
            mux_ph <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state <= next_state;
            blk <= next_blk;
            is_read <= next_is_read;
            dma_active <= next_dma_active;
            dma_reads_disk <= next_dma_reads_disk;
            addr <= next_addr;
            dcnt <= next_dcnt;
            motor <= next_motor;
            fdc_rst <= next_fdc_rst;
            pend_slot <= next_pend_slot;
            mux_ph <= next_mux_ph;
            start_q <= next_start_q;
        end
    end

    // decoded outputs, registered one cycle from the next state
    sdcbi_strobes_t next_strobes;
    logic next_pio;
    logic next_dma;
    logic [7:0] next_status;
    sdcbi_drive_t next_drive;
    always_comb begin
        next_strobes = STROBES_IDLE;
        next_pio = (next_state == SDC_S1) || (next_state == SDC_S3)
            || (next_state == SDC_S2);
        next_dma = (next_state == SDC_DMA) || (next_state == SDC_DEND);
        next_status = {STATUS_PAD[7:3], disk_in_place_in, next_dma_active, fdc_interrupt_in};
        if (next_pio && !next_dma_active) begin
            next_strobes.bus_direction = !next_is_read;
            case (next_blk)
                BLK_FDC_STATUS, BLK_FDC_DATA: begin
                    next_strobes.status_data_select = (next_blk == BLK_FDC_DATA);
                    next_strobes.fdc_read_strobe_n = !next_is_read;
                    next_strobes.fdc_write_strobe_n = next_is_read;
                end
                BLK_DMA_RD, BLK_DMA_WR: begin
                    next_strobes.status_data_select = 1'b1;
                    next_strobes.fdc_write_strobe_n = next_is_read;
                end
                BLK_BUFFER: begin
                    next_strobes.buffer_read_strobe_n = !next_is_read;
                    next_strobes.buffer_write_strobe_n = next_is_read;
                end
                BLK_ROM_RST: next_strobes.rom_read_strobe_n = !next_is_read;
                default: ;
            endcase
        end else if (next_dma) begin
            // disk data moves between controller and buffer
            next_strobes.bus_direction = 1'b1;
            next_strobes.buffer_write_strobe_n = !(next_dma_reads_disk
                && next_state == SDC_DMA);
            next_strobes.buffer_read_strobe_n = next_dma_reads_disk;
        end
        next_drive = drive_in;
        if (next_mux_ph) begin
            next_drive = {drive_in.protect_or_side, drive_in.fault_or_track_zero,
                drive_in.low_current_or_direction, drive_in.fault_reset_or_step};
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cycle_active_n_out <= 1'b1;
            address_load_n_out <= 1'b1;
            ack_window_n_out <= 1'b1;
            ack_n_out <= 1'b1;
            ack_oe_n_out <= 1'b1;
            tm_n_out <= 2'h3;
            tm_oe_n_out <= 1'b1;
            dma_grant_n_out <= 1'b1;
            counter_decrement_n_out <= 1'b1;
            buffer_addr_out <= '0;
            strobes_out <= STROBES_IDLE;
            internal_op_pending_n_out <= 1'b1;
            dma_disk_to_buffer_n_out <= 1'b1;
            status_word_out <= 8'h00;
            motor_on_out <= 1'b0;
            fdc_reset_out <= 1'b0;
            mux_phase_out <= 1'b0;
            drive_out <= '0;
        end else begin
            cycle_active_n_out <= !(next_pio || next_pend_slot);
            address_load_n_out <= !ald;
            ack_window_n_out <= !(next_state == SDC_S2);
            ack_n_out <= !(next_state == SDC_S2);
            ack_oe_n_out <= !(next_state == SDC_S2);
            tm_n_out <= ~TM_OK;
            tm_oe_n_out <= !(next_state == SDC_S2);
            dma_grant_n_out <= !next_dma;
            counter_decrement_n_out <= !(next_state == SDC_DEND && addr != '0);
            buffer_addr_out <= next_addr;
            strobes_out <= next_strobes;
            internal_op_pending_n_out <= !next_dma_active;
            dma_disk_to_buffer_n_out <= !(next_dma_active && next_dma_reads_disk);
            status_word_out <= next_status;
            motor_on_out <= next_motor;
            fdc_reset_out <= next_fdc_rst;
            mux_phase_out <= next_mux_ph;
            drive_out <= next_drive;
        end
    end
endmodule // sdcbi_core

// ===== core/sdcbi_pkg.sv
// sdcbi_pkg: constants, states and carrier structs for the disk card bus interface.
// assumes one bus clock domain; all counts are in bus clock cycles.
package sdcbi_pkg;
    localparam int ADDR_W = 32;
    localparam int BUF_AW = 11;
    localparam int BUF_DEPTH = 2048;
    localparam logic [3:0] SLOT_SPACE_NIBBLE = 4'hF;
    localparam int TOP_NIB_HI = 31;
    localparam int TOP_NIB_LO = 28;
    localparam int SLOT_ID_HI = 27;
    localparam int SLOT_ID_LO = 24;
    // block select field, 128K blocks within slot space
    localparam int BLK_HI = 19;
    localparam int BLK_LO = 17;
    localparam int BUF_ADDR_HI = 12;
    localparam int BUF_ADDR_LO = 2;
    localparam logic [2:0] BLK_FDC_STATUS = 3'h0;
    localparam logic [2:0] BLK_FDC_DATA = 3'h1;
    localparam logic [2:0] BLK_DMA_RD = 3'h2;
    localparam logic [2:0] BLK_DMA_WR = 3'h3;
    localparam logic [2:0] BLK_BUFFER = 3'h4;
    localparam logic [2:0] BLK_RSVD = 3'h5;
    localparam logic [2:0] BLK_MOTOR = 3'h6;
    localparam logic [2:0] BLK_ROM_RST = 3'h7;
    // mux phase count for the four drive signal pairs
    localparam int MUX_PHASES = 2;
    // transfer-mode status driven with ack: complete, no error
    localparam logic [1:0] TM_OK = 2'h0;
    localparam logic [7:0] STATUS_PAD = 8'h00;

    typedef enum logic [2:0] {
        SDC_IDLE = 3'b000,
        SDC_S1 = 3'b001,
        SDC_S3 = 3'b011,
        SDC_S2 = 3'b010,
        SDC_DMA = 3'b100,
        SDC_DEND = 3'b101
    } sdcbi_state_t;

    typedef struct packed {
        logic fdc_write_strobe_n;
        logic fdc_read_strobe_n;
        logic buffer_write_strobe_n;
        logic buffer_read_strobe_n;
        logic rom_read_strobe_n;
        logic status_data_select;
        logic bus_direction;
    } sdcbi_strobes_t;

    typedef struct packed {
        logic fault_or_track_zero;
        logic protect_or_side;
        logic fault_reset_or_step;
        logic low_current_or_direction;
    } sdcbi_drive_t;

    localparam sdcbi_strobes_t STROBES_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
endpackage

// ===== testbench/sdcbi_host_model.sv
// sdcbi_host_model: bus master issuing programmed cycles to the card.
// assumes ack is sampled low on a rising edge; idle lines are pulled up.
module sdcbi_host_model
    import sdcbi_pkg::*;
(
    input wire logic clock_in,
    input wire logic ack_n_in,
    output logic start_n_out,
    output logic [ADDR_W-1:0] ad_n_out,
    output logic tm1_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        start_n_out = 1'b1;
        ad_n_out = '1;
        tm1_n_out = 1'b1;
    end
    // gives up after 16 edges so a refused address cannot hang the bus
    task automatic pio(input logic [ADDR_W-1:0] addr, input bit rd, output bit acked);
        acked = 1'b0;
        @(posedge clock_in);
        start_n_out <= 1'b0;
        ad_n_out <= ~addr;
        tm1_n_out <= !rd;
        for (int i = 0; i < 16 && !acked; i++) begin
            @(posedge clock_in);
            acked = (ack_n_in === 1'b0);
        end
        start_n_out <= 1'b1;
        ad_n_out <= '1;
        tm1_n_out <= 1'b1;
    endtask
endmodule // sdcbi_host_model

// ===== testbench/sdcbi_properties.sv
// sdcbi_properties: port timing checks for the disk card bus interface.
// assumes it is bound into sdcbi_core; one clock domain.
module sdcbi_properties
    import sdcbi_pkg::*;
#(
    parameter int DMA_CYCLE_LEN = 2
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic dma_request_n_in,
    input wire logic cycle_active_n_out,
    input wire logic address_load_n_out,
    input wire logic ack_window_n_out,
    input wire logic ack_n_out,
    input wire logic ack_oe_n_out,
    input wire logic [1:0] tm_n_out,
    input wire logic tm_oe_n_out,
    input wire logic dma_grant_n_out,
    input wire logic [BUF_AW-1:0] buffer_addr_out,
    input wire sdcbi_strobes_t strobes_out,
    input wire logic internal_op_pending_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] grant_cnt;
    logic [7:0] next_grant_cnt;
    // grant length counted here: repetition counts cannot follow the parameter
    always_comb next_grant_cnt = dma_grant_n_out ? 8'h00 : grant_cnt + 8'h01;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in)
            grant_cnt <= 8'h00;
        else
            grant_cnt <= next_grant_cnt;
    end
    sequence pio_hit;
        !address_load_n_out && internal_op_pending_n_out && dma_grant_n_out;
    endsequence
    sequence pio_walk;
        !cycle_active_n_out [*2] ##1 (!cycle_active_n_out && !ack_n_out);
    endsequence
    chk_pio_walk: assert property (pio_hit |-> pio_walk)
        else $error("pio cycle did not walk to ack");
    chk_ack_gate: assert property (!ack_n_out |-> !ack_oe_n_out && !ack_window_n_out)
        else $error("ack driven outside its window");
    chk_tm_status: assert property (!ack_window_n_out |-> !tm_oe_n_out && tm_n_out == ~TM_OK)
        else $error("transfer mode not driven with ack");
    chk_ack_single: assert property (!ack_n_out |=> ack_n_out)
        else $error("ack held beyond one cycle");
    chk_grant_len: assert property ($rose(dma_grant_n_out) |-> grant_cnt == 8'(DMA_CYCLE_LEN + 1))
        else $error("grant length wrong");
    chk_grant_req: assert property ($fell(dma_request_n_in) && !internal_op_pending_n_out
        && cycle_active_n_out |-> ##3 !dma_grant_n_out)
        else $error("request not granted");
    chk_grant_in_op: assert property ($fell(dma_grant_n_out) |-> !internal_op_pending_n_out)
        else $error("grant outside dma operation");
    chk_dec_one: assert property (buffer_addr_out != $past(buffer_addr_out)
        && !internal_op_pending_n_out && !$past(internal_op_pending_n_out, 2)
        |-> buffer_addr_out == $past(buffer_addr_out) - 11'h001)
        else $error("dma address step not minus one");
    chk_read_dir: assert property ((!strobes_out.fdc_read_strobe_n
        || !strobes_out.buffer_read_strobe_n || !strobes_out.rom_read_strobe_n)
        && dma_grant_n_out && internal_op_pending_n_out |-> !strobes_out.bus_direction)
        else $error("read not driven toward bus");
endmodule // sdcbi_properties

// ===== testbench/testbench.sv
// testbench: drives the card through the host model and a dma request line.
// assumes sdcbi_core with default parameters; outputs sampled on falling edges.
module testbench;
    import sdcbi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] SLOT = 4'h9;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic start_n;
    logic [31:0] ad_n;
    logic tm1_n;
    logic dma_request_n_n = 1'b1;
    logic fdc_int = 1'b0;
    logic disk_in = 1'b0;
    sdcbi_drive_t drive_in = 4'hA;
    sdcbi_drive_t drive_out;
    logic ack_n, grant_n, dec_n, pend_n, rd_n, motor, fdc_rst, phase;
    logic [10:0] buf_addr;
    logic [7:0] status;
    sdcbi_strobes_t strobes;
    sdcbi_strobes_t seen;
    int fails = 0;
    int num_checks = 0;
    always #2.5 clock_in = ~clock_in;
    sdcbi_core i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .start_n_in(start_n),
        .ad_n_in(ad_n), .tm1_n_in(tm1_n), .slot_id_n_in(~SLOT), .dma_request_n_in(dma_request_n_n),
        .fdc_interrupt_in(fdc_int), .disk_in_place_in(disk_in), .drive_in(drive_in),
        .cycle_active_n_out(), .address_load_n_out(), .ack_window_n_out(),
        .ack_n_out(ack_n), .ack_oe_n_out(), .tm_n_out(), .tm_oe_n_out(),
        .dma_grant_n_out(grant_n), .counter_decrement_n_out(dec_n),
        .buffer_addr_out(buf_addr), .strobes_out(strobes),
        .internal_op_pending_n_out(pend_n), .dma_disk_to_buffer_n_out(rd_n),
        .status_word_out(status), .motor_on_out(motor), .fdc_reset_out(fdc_rst),
        .mux_phase_out(phase), .drive_out(drive_out));
    sdcbi_host_model i_host (.clock_in(clock_in), .ack_n_in(ack_n), .start_n_out(start_n),
        .ad_n_out(ad_n), .tm1_n_out(tm1_n));
    always @(posedge clock_in)
        if (strobes !== STROBES_IDLE) seen <= strobes;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] adr(input logic [2:0] blk, input logic [10:0] off);
        return {SLOT_SPACE_NIBBLE, SLOT, 4'h0, blk, 4'h0, off, 2'h3};
    endfunction
    task automatic pio(input logic [2:0] blk, input logic [10:0] off, input bit rd);
        bit a;
        i_host.pio(adr(blk, off), rd, a);
        check("ack", 1, a);
        repeat (2) @(negedge clock_in);
    endtask
    task automatic t_reset();
        @(negedge clock_in);
        check("idle", 4'hE, {ack_n, grant_n, pend_n, motor});
        @(negedge clock_in);
        check("phase", 1, phase);
        check("drive swapped", 4'h5, drive_out);
        @(negedge clock_in);
        check("drive_out", drive_in, drive_out);
    endtask
    task automatic t_decode();
        bit a;
        i_host.pio({4'hE, SLOT, 24'h080000}, 1'b1, a);
        check("ack top", 0, a);
        i_host.pio({4'hF, SLOT ^ 4'h1, 24'h080000}, 1'b1, a);
        check("ack slot", 0, a);
    endtask
    task automatic t_strobes();
        logic [2:0] blk [6] = '{3'h0, 3'h1, 3'h1, 3'h4, 3'h4, 3'h7};
        bit rd [6] = '{1, 0, 1, 0, 1, 1};
        logic [6:0] exp [6] = '{7'h5C, 7'h3F, 7'h5E, 7'h6D, 7'h74, 7'h78};
        sdcbi_strobes_t got;
        for (int i = 0; i < 6; i++) begin
            pio(blk[i], 11'h7FF - 11'(i), rd[i]);
            got = seen;
            if (blk[i] > 3'h1) got.status_data_select = 1'b0;
            check("strobes", exp[i], got);
            if (blk[i] == 3'h4) check("buf addr", 11'h7FF - 11'(i), buf_addr);
        end
    endtask
    task automatic t_motor();
        pio(3'h6, 11'h000, 1'b0);
        check("motor", 2'h2, {motor, fdc_rst});
        pio(3'h7, 11'h000, 1'b0);
        pio(3'h5, 11'h000, 1'b0);
        check("reset on", 2'h3, {motor, fdc_rst});
        pio(3'h6, 11'h000, 1'b1);
        check("off", 2'h0, {motor, fdc_rst});
        @(posedge clock_in);
        fdc_int <= 1'b1;
        disk_in <= 1'b1;
        repeat (3) @(negedge clock_in);
        check("status", 8'h05, status);
    endtask
    task automatic dma_byte(input logic [10:0] exp, input bit exp_dec);
        bit dec = 1'b0;
        @(posedge clock_in);
        dma_request_n_n <= 1'b0;
        // two sync flops and the registered state put grant three edges out
        repeat (4) @(negedge clock_in);
        check("grant", 0, grant_n);
        @(posedge clock_in);
        dma_request_n_n <= 1'b1;
        for (int w = 0; w < 8 && grant_n !== 1'b1; w++) begin
            dec |= (dec_n === 1'b0);
            @(negedge clock_in);
        end
        repeat (2) @(negedge clock_in);
        check("decrement", exp_dec, dec);
        check("buf addr", exp, buf_addr);
    endtask
    task automatic t_dma();
        pio(3'h2, 11'h003, 1'b0);
        check("op", 2'h0, {pend_n, rd_n});
        check("status", 8'h07, status);
        check("start addr", 11'h003, buf_addr);
        pio(3'h6, 11'h000, 1'b0);
        check("motor", 0, motor);
        for (int n = 2; n >= 0; n--) dma_byte(11'(n), 1'b1);
        // the cycle at address zero moves its byte and ends the operation
        dma_byte(11'h000, 1'b0);
        check("op end", 2'h3, {pend_n, rd_n});
        pio(3'h3, 11'h001, 1'b0);
        check("op wr", 2'h1, {pend_n, rd_n});
        dma_byte(11'h000, 1'b1);
        dma_byte(11'h000, 1'b0);
        check("op end", 1, pend_n);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_reset();
        $display("done reset");
        t_decode();
        $display("done decode");
        t_strobes();
        $display("done strobes");
        t_motor();
        $display("done motor");
        t_dma();
        $display("done dma");
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        fails++;
        give_verdict();
    end
endmodule // testbench
bind sdcbi_core sdcbi_properties #(.DMA_CYCLE_LEN(DMA_CYCLE_LEN)) i_props (.clock_in, .rstn_in,
    .dma_request_n_in, .cycle_active_n_out, .address_load_n_out, .ack_window_n_out,
    .ack_n_out, .ack_oe_n_out, .tm_n_out, .tm_oe_n_out, .dma_grant_n_out,
    .buffer_addr_out, .strobes_out, .internal_op_pending_n_out);
